// file: rtl/scpi_parser_pkg.sv
/*
  Shared constants and types for the program message parser.
  Assumes one byte-wide character stream and a single clock domain.
*/
`default_nettype none

package scpi_parser_pkg;

  // ----------------------------------------------------------------
  // Sizes
  // ----------------------------------------------------------------
  localparam int KW_COUNT = 24;
  localparam logic [3:0] MAX_CHARS = 4'd12;
  localparam logic [2:0] MAX_DEPTH = 3'd4;

  // ----------------------------------------------------------------
  // Characters
  // ----------------------------------------------------------------
  localparam logic [7:0] CH_LF = 8'h0a;
  localparam logic [7:0] CH_CR = 8'h0d;
  localparam logic [7:0] CH_SPACE = 8'h20;
  localparam logic [7:0] CH_STAR = 8'h2a;
  localparam logic [7:0] CH_COLON = 8'h3a;
  localparam logic [7:0] CH_SEMI = 8'h3b;
  localparam logic [7:0] CH_QUERY = 8'h3f;
  localparam logic [7:0] CH_DIGIT_0 = 8'h30;
  localparam logic [7:0] CH_DIGIT_9 = 8'h39;
  localparam logic [7:0] CH_UPPER_A = 8'h41;
  localparam logic [7:0] CH_UPPER_Z = 8'h5a;
  localparam logic [7:0] CH_LOWER_A = 8'h61;
  localparam logic [7:0] CH_LOWER_Z = 8'h7a;
  localparam logic [7:0] CASE_BIT = 8'h20;

  // ----------------------------------------------------------------
  // Keyword table: code is index plus one, zero means no match
  // ----------------------------------------------------------------
  typedef logic [4:0] kw_code_t;
  localparam kw_code_t KW_NONE = 5'h00;
  localparam kw_code_t KW_SOURCE = 5'h04;
  localparam kw_code_t KW_LAST_ROOT = 5'h09;

  localparam logic [95:0] KW_TEXT [KW_COUNT] = '{
    {"INITIATE", 32'h0}, {"MEASURE", 40'h0}, {"OUTPUT", 48'h0},
    {"SOURCE", 48'h0}, {"STATUS", 48'h0}, {"SYSTEM", 48'h0},
    {"VOLTAGE", 40'h0}, {"CURRENT", 40'h0}, {"FUNCTION", 32'h0},
    {"LEVEL", 56'h0}, {"IMMEDIATE", 24'h0}, {"TRIGGERED", 24'h0},
    {"MODE", 64'h0}, {"RANGE", 56'h0}, {"STATE", 56'h0},
    {"OPERATION", 24'h0}, {"PRESET", 48'h0}, {"QUESTIONABLE"},
    {"CONDITION", 24'h0}, {"ENABLE", 48'h0}, {"EVENT", 56'h0},
    {"ERROR", 56'h0}, {"AUTO", 64'h0}, {"VERSION", 40'h0}
  };
  localparam logic [3:0] KW_SHORT [KW_COUNT] = '{
    4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h3, 4'h3, 4'h4,
    4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h4, 4'h3, 4'h4, 4'h4
  };
  localparam logic [3:0] KW_LONG [KW_COUNT] = '{
    4'h8, 4'h7, 4'h6, 4'h6, 4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h5, 4'h9, 4'h9,
    4'h4, 4'h5, 4'h5, 4'h9, 4'h6, 4'hc, 4'h9, 4'h6, 4'h5, 4'h5, 4'h4, 4'h7
  };

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum {
    ST_UNIT_START,
    ST_AFTER_COLON,
    ST_KEYWORD,
    ST_AFTER_QUERY,
    ST_PARAM,
    ST_COMMON,
    ST_DISCARD
  } state_e;

  typedef enum logic [2:0] {
    ERR_NONE,
    ERR_KEYWORD,
    ERR_ROOT,
    ERR_SYNTAX,
    ERR_DEPTH
  } err_e;

  typedef struct packed {
    kw_code_t [3:0] path;
    logic [2:0] path_len;
    logic is_query;
    logic is_common;
    logic has_param;
    logic [95:0] word;
  } unit_s;

endpackage

`default_nettype wire

// file: rtl/scpi_message_parser.sv
/*
  Program message parser: turns a host character stream into decoded
  message units with their tree path, query flag and parameter bytes.
  Assumes one byte per cycle at most, inputs synchronous to i_clk, and
  no back-pressure: every valid byte is consumed in its cycle.
*/
// Notes on behaviour
// RQ1: Keywords accepted in long or short spelling
// RQ2: Letter case ignored when matching keywords
// RQ3: Partial spellings rejected with an error
// RQ4: Colon separates keywords, moves one level deeper
// RQ5: Question mark after last keyword makes query
// RQ6: Parameter follows keyword after one space
// RQ7: Semicolon separates message units
// RQ8: Leading colon resets position to root
// RQ9: Unit without colon continues previous parent path
// RQ10: LF, CR or CR LF end a message
// RQ11: LF right after CR is ignored
// RQ12: Host ends every message with terminator
// RQ13: Terminator returns tree position to root
// RQ14: Optional source root keyword may be omitted
// RQ15: Only listed root keywords accepted at top
// RQ16: Next unit decoded at last colon level
// RQ17: Asterisk unit decoded as common command
// RQ18: Host uses bus end for binary data
// RQ19: First unit of message starts at root
// RQ20: Syntax error flags and discards the unit
`timescale 1ns/10ps
`default_nettype none

module scpi_message_parser (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_byte_end,
  output logic o_unit_valid,
  output scpi_parser_pkg::unit_s o_unit,
  output logic o_param_valid,
  output logic [7:0] o_param_byte,
  output logic o_error,
  output scpi_parser_pkg::err_e o_error_cause,
  output logic o_msg_end
);

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;

  always_ff @(posedge i_clk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // Parser state
  // ----------------------------------------------------------------
  scpi_parser_pkg::state_e state;
  scpi_parser_pkg::state_e next_state;
  logic [95:0] word;
  logic [95:0] next_word;
  logic [3:0] word_len;
  logic [3:0] next_word_len;
  logic [2:0] depth;
  logic [2:0] next_depth;
  scpi_parser_pkg::kw_code_t [3:0] path;
  scpi_parser_pkg::kw_code_t [3:0] next_path;
  logic [2:0] path_len;
  logic [2:0] next_path_len;
  logic query;
  logic next_query;
  logic param;
  logic next_param;
  logic common;
  logic next_common;
  logic prev_cr;

  // ----------------------------------------------------------------
  // Character classes
  // ----------------------------------------------------------------
  logic [7:0] up;
  logic is_letter;
  logic is_digit;
  logic is_cr;
  logic is_lf;
  logic skip_lf;
  logic take;
  logic is_term;

  always_comb begin
    up = i_byte;
    if (i_byte >= scpi_parser_pkg::CH_LOWER_A && i_byte <= scpi_parser_pkg::CH_LOWER_Z) begin
      up = i_byte - scpi_parser_pkg::CASE_BIT; // [RQ2]
    end
    is_letter = up >= scpi_parser_pkg::CH_UPPER_A && up <= scpi_parser_pkg::CH_UPPER_Z;
    is_digit = up >= scpi_parser_pkg::CH_DIGIT_0 && up <= scpi_parser_pkg::CH_DIGIT_9;
    is_cr = i_byte == scpi_parser_pkg::CH_CR;
    is_lf = i_byte == scpi_parser_pkg::CH_LF;
    skip_lf = is_lf && prev_cr; // [RQ11]
    take = i_byte_valid && !skip_lf;
    is_term = is_cr || is_lf || i_byte_end; // [RQ10]
  end

  // CR flag so a following LF is swallowed
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      prev_cr <= 1'b0;
    end else if (i_byte_valid) begin
      prev_cr <= is_cr && !skip_lf; // [RQ11]
    end
  end

  // ----------------------------------------------------------------
  // Keyword lookup
  // ----------------------------------------------------------------
  scpi_parser_pkg::kw_code_t kw_hit;
  logic kw_root_ok;

  always_comb begin
    logic same;
    same = 1'b1;
    kw_hit = scpi_parser_pkg::KW_NONE;
    for (int i = 0; i < scpi_parser_pkg::KW_COUNT; i++) begin
      same = 1'b1;
      for (int j = 0; j < 12; j++) begin
        if (4'(j) < word_len && word[95 - 8 * j -: 8] != scpi_parser_pkg::KW_TEXT[i][95 - 8 * j -: 8]) begin
          same = 1'b0;
        end
      end
      // Only the exact short or complete long length may match
      // Shared short spelling: top level keeps the root word, deeper ones the later
      if (same && word_len != 4'h0 && (kw_hit == scpi_parser_pkg::KW_NONE || depth != 3'd0) &&
          (word_len == scpi_parser_pkg::KW_SHORT[i] || word_len == scpi_parser_pkg::KW_LONG[i])) begin
        kw_hit = 5'(i + 1); // [RQ1] [RQ3]
      end
    end
    kw_root_ok = depth != 3'd0 || kw_hit <= scpi_parser_pkg::KW_LAST_ROOT; // [RQ15]
  end

  // ----------------------------------------------------------------
  // Next-state decode
  // ----------------------------------------------------------------
  logic emit;
  logic err;
  scpi_parser_pkg::err_e cause;
  logic pass_param;
  logic msg_end;
  logic placed;

  always_comb begin
    next_state = state;
    next_word = word;
    next_word_len = word_len;
    next_depth = depth;
    next_path = path;
    next_path_len = path_len;
    next_query = query;
    next_param = param;
    next_common = common;
    emit = 1'b0;
    err = 1'b0;
    cause = scpi_parser_pkg::ERR_NONE;
    pass_param = 1'b0;
    msg_end = 1'b0;
    placed = 1'b0;
    if (take) begin
      case (state)
        scpi_parser_pkg::ST_UNIT_START: begin
          next_query = 1'b0;
          next_param = 1'b0;
          next_common = 1'b0;
          next_word = '0;
          next_word_len = 4'h0;
          if (is_term) begin
            next_state = scpi_parser_pkg::ST_UNIT_START;
          end else if (i_byte == scpi_parser_pkg::CH_SPACE) begin
            next_state = scpi_parser_pkg::ST_UNIT_START;
          end else if (i_byte == scpi_parser_pkg::CH_COLON) begin
            next_depth = 3'd0; // [RQ8]
            next_path_len = 3'd0;
            next_state = scpi_parser_pkg::ST_AFTER_COLON;
          end else if (i_byte == scpi_parser_pkg::CH_STAR) begin
            next_common = 1'b1; // [RQ17]
            next_path_len = 3'd0;
            next_state = scpi_parser_pkg::ST_COMMON;
          end else if (is_letter) begin
            // Depth still holds the level of the previous unit's last keyword
            next_path_len = depth; // [RQ9] [RQ16]
            next_word[95 -: 8] = up;
            next_word_len = 4'h1;
            next_state = scpi_parser_pkg::ST_KEYWORD;
          end else begin
            err = 1'b1;
            cause = scpi_parser_pkg::ERR_SYNTAX; // [RQ20]
            next_state = scpi_parser_pkg::ST_DISCARD;
          end
        end
        scpi_parser_pkg::ST_AFTER_COLON: begin
          if (is_letter && !is_term) begin
            next_word = '0;
            next_word[95 -: 8] = up;
            next_word_len = 4'h1;
            next_state = scpi_parser_pkg::ST_KEYWORD;
          end else begin
            err = 1'b1;
            cause = scpi_parser_pkg::ERR_SYNTAX; // [RQ20]
            next_state = i_byte == scpi_parser_pkg::CH_SEMI ? scpi_parser_pkg::ST_UNIT_START
                                                            : scpi_parser_pkg::ST_DISCARD;
            next_depth = 3'd0;
          end
        end
        scpi_parser_pkg::ST_KEYWORD: begin
          if (is_letter && !is_term) begin
            if (word_len == scpi_parser_pkg::MAX_CHARS) begin
              err = 1'b1;
              cause = scpi_parser_pkg::ERR_KEYWORD; // [RQ3]
              next_state = scpi_parser_pkg::ST_DISCARD;
            end else begin
              for (int j = 0; j < 12; j++) begin
                if (4'(j) == word_len) begin
                  next_word[95 - 8 * j -: 8] = up;
                end
              end
              next_word_len = word_len + 4'h1;
            end
          end else if (!(is_term || i_byte == scpi_parser_pkg::CH_COLON ||
                         i_byte == scpi_parser_pkg::CH_QUERY ||
                         i_byte == scpi_parser_pkg::CH_SPACE ||
                         i_byte == scpi_parser_pkg::CH_SEMI)) begin
            err = 1'b1;
            cause = scpi_parser_pkg::ERR_SYNTAX; // [RQ20]
            next_state = scpi_parser_pkg::ST_DISCARD;
          end else if (kw_hit == scpi_parser_pkg::KW_NONE || !kw_root_ok) begin
            err = 1'b1;
            cause = kw_hit == scpi_parser_pkg::KW_NONE ? scpi_parser_pkg::ERR_KEYWORD
                                                     : scpi_parser_pkg::ERR_ROOT; // [RQ3] [RQ15]
            next_state = i_byte == scpi_parser_pkg::CH_SEMI ? scpi_parser_pkg::ST_UNIT_START
                                                            : scpi_parser_pkg::ST_DISCARD;
            next_depth = 3'd0;
          end else begin
            // Optional source root adds no level of its own
            placed = !(kw_hit == scpi_parser_pkg::KW_SOURCE && depth == 3'd0); // [RQ14]
            if (placed) begin
              next_path[depth[1:0]] = kw_hit;
              next_path_len = depth + 3'd1;
            end
            if (i_byte == scpi_parser_pkg::CH_COLON) begin
              next_depth = placed ? depth + 3'd1 : depth; // [RQ4]
              next_state = scpi_parser_pkg::ST_AFTER_COLON;
              if (next_depth == scpi_parser_pkg::MAX_DEPTH) begin
                err = 1'b1;
                cause = scpi_parser_pkg::ERR_DEPTH;
                next_depth = 3'd0;
                next_state = scpi_parser_pkg::ST_DISCARD;
              end
            end else if (i_byte == scpi_parser_pkg::CH_QUERY) begin
              next_query = 1'b1; // [RQ5]
              next_state = scpi_parser_pkg::ST_AFTER_QUERY;
            end else if (i_byte == scpi_parser_pkg::CH_SPACE) begin
              next_param = 1'b1; // [RQ6]
              next_state = scpi_parser_pkg::ST_PARAM;
            end else begin
              emit = 1'b1; // [RQ7]
              next_state = scpi_parser_pkg::ST_UNIT_START;
            end
          end
        end
        scpi_parser_pkg::ST_AFTER_QUERY: begin
          if (i_byte == scpi_parser_pkg::CH_SPACE && !is_term) begin
            next_param = 1'b1; // [RQ6]
            next_state = scpi_parser_pkg::ST_PARAM;
          end else if (is_term || i_byte == scpi_parser_pkg::CH_SEMI) begin
            emit = 1'b1; // [RQ7]
            next_state = scpi_parser_pkg::ST_UNIT_START;
          end else begin
            err = 1'b1;
            cause = scpi_parser_pkg::ERR_SYNTAX; // [RQ20]
            next_state = scpi_parser_pkg::ST_DISCARD;
          end
        end
        scpi_parser_pkg::ST_PARAM, scpi_parser_pkg::ST_COMMON: begin
          if (is_term || i_byte == scpi_parser_pkg::CH_SEMI) begin
            // Byte other than CR or LF flagged with bus end is still data inside a parameter
            pass_param = param && i_byte_end && !is_cr && !is_lf;
            emit = 1'b1; // [RQ7]
            next_state = scpi_parser_pkg::ST_UNIT_START;
          end else if (state == scpi_parser_pkg::ST_PARAM) begin
            pass_param = 1'b1; // [RQ6]
          end else if (i_byte == scpi_parser_pkg::CH_SPACE) begin
            next_param = 1'b1;
            next_state = scpi_parser_pkg::ST_PARAM;
          end else if (i_byte == scpi_parser_pkg::CH_QUERY) begin
            next_query = 1'b1;
          end else if ((is_letter || is_digit) && word_len != scpi_parser_pkg::MAX_CHARS) begin
            for (int j = 0; j < 12; j++) begin
              if (4'(j) == word_len) begin
                next_word[95 - 8 * j -: 8] = up; // [RQ17]
              end
            end
            next_word_len = word_len + 4'h1;
          end else begin
            err = 1'b1;
            cause = scpi_parser_pkg::ERR_SYNTAX; // [RQ20]
            next_state = scpi_parser_pkg::ST_DISCARD;
          end
        end
        scpi_parser_pkg::ST_DISCARD: begin
          if (i_byte == scpi_parser_pkg::CH_SEMI) begin
            next_depth = 3'd0;
            next_state = scpi_parser_pkg::ST_UNIT_START; // [RQ20]
          end
        end
        default: begin
          next_state = scpi_parser_pkg::ST_UNIT_START;
        end
      endcase
      if (is_term) begin
        msg_end = 1'b1;
        next_depth = 3'd0; // [RQ13] [RQ19]
        next_state = scpi_parser_pkg::ST_UNIT_START;
      end
    end
  end

  // ----------------------------------------------------------------
  // State registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= scpi_parser_pkg::ST_UNIT_START;
      word <= '0;
      word_len <= 4'h0;
      depth <= 3'd0;
      path <= '0;
      path_len <= 3'd0;
      query <= 1'b0;
      param <= 1'b0;
      common <= 1'b0;
    end else begin
      state <= next_state;
      word <= next_word;
      word_len <= next_word_len;
      depth <= next_depth;
      path <= next_path;
      path_len <= next_path_len;
      query <= next_query;
      param <= next_param;
      common <= next_common;
    end
  end

  // ----------------------------------------------------------------
  // Output registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk or negedge rst_n) begin
    if (!rst_n) begin
      o_unit_valid <= 1'b0;
      o_unit <= '0;
      o_param_valid <= 1'b0;
      o_param_byte <= 8'h00;
      o_error <= 1'b0;
      o_error_cause <= scpi_parser_pkg::ERR_NONE;
      o_msg_end <= 1'b0;
    end else begin
      o_unit_valid <= emit;
      if (emit) begin
        o_unit <= {next_path, next_path_len, next_query, next_common, next_param, next_word};
      end
      o_param_valid <= pass_param;
      if (pass_param) begin
        o_param_byte <= i_byte;
      end
      o_error <= err;
      if (err) begin
        o_error_cause <= cause;
      end
      o_msg_end <= msg_end;
    end
  end

endmodule

`default_nettype wire

// file: sim/scpi_message_parser_props.sv
/*
  Concurrent checks on the message parser ports.
  Assumes one clock, async active-low reset, bound to the parser top.
*/
`timescale 1ns/10ps
`default_nettype none

module scpi_message_parser_props (
  input wire logic i_clk,
  input wire logic i_reset_n,
  input wire logic i_byte_valid,
  input wire logic [7:0] i_byte,
  input wire logic i_byte_end,
  input wire logic o_unit_valid,
  input wire scpi_parser_pkg::unit_s o_unit,
  input wire logic o_param_valid,
  input wire logic [7:0] o_param_byte,
  input wire logic o_error,
  input wire scpi_parser_pkg::err_e o_error_cause,
  input wire logic o_msg_end
);
  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  wire logic is_term = i_byte_valid && (i_byte == scpi_parser_pkg::CH_LF ||
      i_byte == scpi_parser_pkg::CH_CR || i_byte_end);
  wire logic is_semi = i_byte_valid && i_byte == scpi_parser_pkg::CH_SEMI;

  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_reset_n);

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  a_msg_end_cause: assert property (o_msg_end |-> $past(is_term))
    else $error("message end without terminator byte");
  a_cr_lf_quiet: assert property (
    (i_byte_valid && i_byte == scpi_parser_pkg::CH_CR) ##1
    (i_byte_valid && i_byte == scpi_parser_pkg::CH_LF && !i_byte_end)
    |=> !o_msg_end && !o_unit_valid && !o_error)
    else $error("line feed after carriage return had an effect");
  a_unit_end_cause: assert property (
    o_unit_valid |-> $past(is_term) || $past(is_semi))
    else $error("unit completed without separator or terminator");
  a_term_ends_msg: assert property (o_unit_valid && $past(is_term) |-> o_msg_end)
    else $error("unit closed by terminator without message end");
  a_param_echo: assert property (
    o_param_valid |-> $past(i_byte_valid) && o_param_byte == $past(i_byte))
    else $error("parameter byte differs from received byte");
  a_depth_bound: assert property (
    o_unit_valid && !o_unit.is_common |->
    o_unit.path_len inside {[1:scpi_parser_pkg::MAX_DEPTH]})
    else $error("unit path length out of range");
  a_root_keyword: assert property (
    o_unit_valid && !o_unit.is_common |->
    o_unit.path[0] inside {[1:scpi_parser_pkg::KW_LAST_ROOT]})
    else $error("unit top keyword outside root set");
  a_error_drops_unit: assert property (o_error |-> !o_unit_valid)
    else $error("unit delivered together with error");
  a_idle_quiet: assert property (
    !$past(i_byte_valid) |-> !(o_unit_valid || o_msg_end || o_error || o_param_valid))
    else $error("output pulse without an input byte");

  c_query: cover property (o_unit_valid && o_unit.is_query);
  c_error: cover property (o_error);
  c_end_in_param: cover property (o_param_valid && o_unit_valid && o_msg_end);
endmodule

bind scpi_message_parser scpi_message_parser_props i_props (
  .i_clk(i_clk),
  .i_reset_n(i_reset_n),
  .i_byte_valid(i_byte_valid),
  .i_byte(i_byte),
  .i_byte_end(i_byte_end),
  .o_unit_valid(o_unit_valid),
  .o_unit(o_unit),
  .o_param_valid(o_param_valid),
  .o_param_byte(o_param_byte),
  .o_error(o_error),
  .o_error_cause(o_error_cause),
  .o_msg_end(o_msg_end)
);
`default_nettype wire

// file: sim/scpi_host_model.sv
/*
  Behavioural host controller: sends program messages one byte a cycle.
  Assumes the parser takes every byte; no back-pressure exists.
*/
`timescale 1ns/10ps
`default_nettype none

module scpi_host_model (
  input wire logic i_clk,
  output logic o_valid,
  output logic [7:0] o_byte,
  output logic o_end
);
  initial begin
    o_valid = 1'b0;
    o_byte = 8'h00;
    o_end = 1'b0;
  end

  // ----------------------------------------------------------------
  // Sender
  // ----------------------------------------------------------------
  // Caller supplies complete spellings and separators
  // Text ends in a terminator, or flag_end marks the last byte
  task automatic send(input string s, input bit flag_end);
    @(posedge i_clk);
    #1;
    for (int i = 0; i < s.len(); i++) begin
      o_valid = 1'b1;
      o_byte = s[i];
      o_end = flag_end && (i == s.len() - 1);
      @(posedge i_clk);
      #1;
    end
    // Released data line shows inverse, not a stale copy
    o_valid = 1'b0;
    o_end = 1'b0;
    o_byte = ~o_byte;
  endtask
endmodule
`default_nettype wire

// file: sim/scpi_message_parser_tb_top.sv
/*
  Self-checking bench for the message parser, driven by the host model.
  Assumes a 20 MHz clock and the checker bound from its own file.
*/
`timescale 1ns/10ps
`default_nettype none

module scpi_message_parser_tb_top;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic byte_valid, byte_end, unit_valid, param_valid, error, msg_end;
  logic [7:0] byte_in, param_byte;
  scpi_parser_pkg::unit_s unit;
  scpi_parser_pkg::err_e cause;
  scpi_parser_pkg::unit_s units[$];
  logic [7:0] params[$];
  int err_total = 0;
  int n_compared = 0;
  int n_err = 0;
  int n_end = 0;
  int cycles = 0;

  initial begin
    forever #25 clk = ~clk;
  end

  scpi_host_model i_host (.i_clk(clk), .o_valid(byte_valid), .o_byte(byte_in),
    .o_end(byte_end));

  scpi_message_parser i_dut (.i_clk(clk), .i_reset_n(reset_n), .i_byte_valid(byte_valid),
    .i_byte(byte_in), .i_byte_end(byte_end), .o_unit_valid(unit_valid), .o_unit(unit),
    .o_param_valid(param_valid), .o_param_byte(param_byte), .o_error(error),
    .o_error_cause(cause), .o_msg_end(msg_end));

  // ----------------------------------------------------------------
  // Monitor
  // ----------------------------------------------------------------
  // Falling edge sampling keeps clear of the launching edge
  always @(negedge clk) begin
    if (unit_valid === 1'b1) units.push_back(unit);
    if (param_valid === 1'b1) params.push_back(param_byte);
    if (error === 1'b1) n_err++;
    if (msg_end === 1'b1) n_end++;
  end

  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_total++;
      end_of_test();
    end
  end

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [127:0] seen, input logic [127:0] exp);
    n_compared++;
    if (seen !== exp) begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  // Stale path entries and the word are masked out
  function automatic logic [127:0] key(input scpi_parser_pkg::unit_s u);
    for (int i = 0; i < 4; i++) begin
      if (i >= u.path_len) u.path[i] = '0;
    end
    u.word = '0;
    return 128'(u);
  endfunction

  task automatic run(input string s, input bit flag_end);
    units.delete();
    params.delete();
    n_err = 0;
    n_end = 0;
    i_host.send(s, flag_end);
    repeat (3) @(posedge clk);
  endtask

  task automatic exp_unit(input int idx, input logic [4:0] a, input logic [4:0] b,
      input logic [4:0] c, input logic [2:0] len, input logic q, input logic p);
    scpi_parser_pkg::unit_s e;
    e = '0;
    e.path[0] = a;
    e.path[1] = b;
    e.path[2] = c;
    e.path_len = len;
    e.is_query = q;
    e.has_param = p;
    if (idx < units.size()) check(key(units[idx]), key(e));
    else check(128'h0, 128'h1);
  endtask

  task automatic exp_error(input scpi_parser_pkg::err_e want);
    check(128'(units.size()), 128'h0);
    check(128'(n_err), 128'h1);
    check(128'(cause), 128'(want));
    check(128'(n_end), 128'h1);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  task automatic s_forms();
    string forms[4] = '{"volt?\n", "VOLTAGE?\n", "VoLtAgE?\n", ":vOlT?\n"};
    foreach (forms[i]) begin
      run(forms[i], 1'b0);
      check(128'(units.size()), 128'h1);
      exp_unit(0, 5'd7, 5'd0, 5'd0, 3'd1, 1'b1, 1'b0);
    end
  endtask

  task automatic s_partial();
    string bad[3] = '{"volta\n", "outpu?\n", "imme\n"};
    foreach (bad[i]) begin
      run(bad[i], 1'b0);
      exp_error(scpi_parser_pkg::ERR_KEYWORD);
    end
  endtask

  task automatic s_tree();
    run("stat:oper:cond?;enab 16\n", 1'b0);
    check(128'(units.size()), 128'h2);
    exp_unit(0, 5'd5, 5'd16, 5'd19, 3'd3, 1'b1, 1'b0);
    exp_unit(1, 5'd5, 5'd16, 5'd20, 3'd3, 1'b0, 1'b1);
    check(128'(params.size()), 128'h2);
    if (params.size() == 2) check(128'({params[0], params[1]}), 128'h3136);
  endtask

  task automatic s_root();
    run("meas:volt?;:curr?\r", 1'b0);
    exp_unit(0, 5'd2, 5'd7, 5'd0, 3'd2, 1'b1, 1'b0);
    exp_unit(1, 5'd8, 5'd0, 5'd0, 3'd1, 1'b1, 1'b0);
    check(128'(n_end), 128'h1);
    run("stat:pres\r\n", 1'b0);
    check(128'(n_end), 128'h1);
    run("curr?\n", 1'b0);
    exp_unit(0, 5'd8, 5'd0, 5'd0, 3'd1, 1'b1, 1'b0);
  endtask

  task automatic s_source();
    run(":sour:volt 1\n", 1'b0);
    exp_unit(0, 5'd7, 5'd0, 5'd0, 3'd1, 1'b0, 1'b1);
    run("syst:vers?;:init\n", 1'b0);
    exp_unit(0, 5'd6, 5'd24, 5'd0, 3'd2, 1'b1, 1'b0);
    exp_unit(1, 5'd1, 5'd0, 5'd0, 3'd1, 1'b0, 1'b0);
  endtask

  task automatic s_common();
    run("*rst;outp?\n", 1'b0);
    check(128'(units.size()), 128'h2);
    if (units.size() > 0) check(128'(units[0].is_common), 128'h1);
    if (units.size() > 0) check(128'(units[0].word), 128'({"RST", 72'h0}));
    exp_unit(1, 5'd3, 5'd0, 5'd0, 3'd1, 1'b1, 1'b0);
  endtask

  task automatic s_end_flag();
    run("curr 5", 1'b1);
    exp_unit(0, 5'd8, 5'd0, 5'd0, 3'd1, 1'b0, 1'b1);
    check(128'(params.size()), 128'h1);
    check(128'(n_end), 128'h1);
  endtask

  task automatic s_faults();
    run("lev\n", 1'b0);
    exp_error(scpi_parser_pkg::ERR_ROOT);
    run("stat:oper:cond:even:ques?\n", 1'b0);
    exp_error(scpi_parser_pkg::ERR_DEPTH);
    run("volt:lev; curr?\n", 1'b0);
    check(128'(n_end), 128'h1);
  endtask

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  task automatic end_of_test();
    $display("Compared %0d, mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge clk);
    #1;
    reset_n = 1'b1;
    repeat (3) @(posedge clk);
    s_forms();
    s_partial();
    s_tree();
    s_root();
    s_source();
    s_common();
    s_end_flag();
    s_faults();
    end_of_test();
  end
endmodule
`default_nettype wire
